// ---- hw/ipb_consts.svh ----
// Offsets, field positions, masks and reset values of the priority bank
`ifndef IPB_CONSTS_SVH
`define IPB_CONSTS_SVH

`define IPB_NREG 7
`define IPB_NSRC 16

`define IPB_OFS_CTRL3 8'h0c
`define IPB_OFS_CTRL4 8'h10
`define IPB_OFS_CTRL5 8'h14
`define IPB_OFS_CTRL7 8'h1c
`define IPB_OFS_CTRL15 8'h3c
`define IPB_OFS_CTRL16 8'h40
`define IPB_OFS_CTRL18 8'h48
`define IPB_OFS_STAT 8'h60

`define IPB_MASK_CTRL3 16'h7077
`define IPB_MASK_CTRL4 16'h7777
`define IPB_MASK_CTRL5 16'h0007
`define IPB_MASK_CTRL7 16'h7770
`define IPB_MASK_CTRL15 16'h0700
`define IPB_MASK_CTRL16 16'h7770
`define IPB_MASK_CTRL18 16'h0007

`define IPB_RST_CTRL3 16'h4044
`define IPB_RST_CTRL4 16'h4444
`define IPB_RST_CTRL5 16'h0004
`define IPB_RST_CTRL7 16'h4440
`define IPB_RST_CTRL15 16'h0400
`define IPB_RST_CTRL16 16'h4440
`define IPB_RST_CTRL18 16'h0004

`define IPB_POS_HI 4'hc
`define IPB_POS_MH 4'h8
`define IPB_POS_ML 4'h4
`define IPB_POS_LO 4'h0

`define IPB_STAT_REQ 15
`define IPB_STAT_LVL 8
`define IPB_STAT_SRC 0

`endif

// ---- hw/ipb_pkg.sv ----
// Types shared by the priority bank and its users
package ipb_pkg;

	typedef logic [2:0] ipb_level_t;

	typedef struct packed
	{
		logic req;
		ipb_level_t level;
		logic [3:0] source;
	} ipb_irq_t;

endpackage : ipb_pkg

// ---- hw/ipb_priority_bank.sv ----
// Interrupt priority register bank with highest-level arbitration
`timescale 1ns/100ps
`include "ipb_consts.svh"

// Notes on behaviour
// - Fields are three bits; 111 gives level 7, the highest.
// - Code 001 is level 1, the lowest; codes between map linearly.
// - Code 000 disables a source; it never requests.
// - Unimplemented bits read as zero.
// - Ctrl 3: memory 14-12, conversion 6-4, serial1 transmit 2-0.
// - Ctrl 4: pin change 14-12, comparator 10-8.
// - Ctrl 4: two-wire master 6-4, two-wire slave 2-0.
// - Ctrl 5: only external irq 1 at 2-0.
// - Ctrl 7: serial2 transmit 14-12, receive 10-8, external irq 2 6-4.
// - Ctrl 15: only calendar clock at 10-8.
// - Ctrl 16: checksum 14-12, serial2 error 10-8, serial1 error 6-4.
// - Ctrl 18: only voltage detect at 2-0.
// - After reset every source sits at level 4.
// - A request reaches the core only above the core's current level.
module ipb_priority_bank
	import ipb_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Avalon-MM slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Interrupt sources
	input wire logic [15:0] src_flag,
	input wire logic [15:0] src_enable,
	// Processor core
	input wire logic [3:0] cpu_level,
	output ipb_irq_t irq
);

	localparam logic [7:0] REG_OFS [`IPB_NREG] = '{`IPB_OFS_CTRL3, `IPB_OFS_CTRL4,
		`IPB_OFS_CTRL5, `IPB_OFS_CTRL7, `IPB_OFS_CTRL15, `IPB_OFS_CTRL16, `IPB_OFS_CTRL18};
	localparam logic [15:0] REG_MASK [`IPB_NREG] = '{`IPB_MASK_CTRL3, `IPB_MASK_CTRL4,
		`IPB_MASK_CTRL5, `IPB_MASK_CTRL7, `IPB_MASK_CTRL15, `IPB_MASK_CTRL16,
		`IPB_MASK_CTRL18};
	localparam logic [15:0] REG_RST [`IPB_NREG] = '{`IPB_RST_CTRL3, `IPB_RST_CTRL4,
		`IPB_RST_CTRL5, `IPB_RST_CTRL7, `IPB_RST_CTRL15, `IPB_RST_CTRL16,
		`IPB_RST_CTRL18};
	// Slot and field position of each source, in source index order
	localparam logic [2:0] SRC_SLOT [`IPB_NSRC] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1,
		3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h5, 3'h5, 3'h5, 3'h6};
	localparam logic [3:0] SRC_POS [`IPB_NSRC] = '{`IPB_POS_HI, `IPB_POS_ML,
		`IPB_POS_LO, `IPB_POS_HI, `IPB_POS_MH, `IPB_POS_ML, `IPB_POS_LO, `IPB_POS_LO,
		`IPB_POS_HI, `IPB_POS_MH, `IPB_POS_ML, `IPB_POS_MH, `IPB_POS_HI, `IPB_POS_MH,
		`IPB_POS_ML, `IPB_POS_LO};

	logic [15:0] regs_q [`IPB_NREG];
	logic [15:0] regs_d [`IPB_NREG];
	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	ipb_irq_t irq_q;
	ipb_irq_t irq_d;
	logic hit;
	logic [2:0] slot;
	logic is_stat;
	logic [15:0] stat;
	logic [15:0] merged;
	ipb_level_t src_level [`IPB_NSRC];
	ipb_level_t live_level [`IPB_NSRC];
	ipb_level_t best_lvl;
	logic [3:0] best_src;

	assign readdata = rdata_q;
	assign waitrequest = wait_q;
	assign irq = irq_q;

	// Address decode
	always_comb
	begin
		hit = 1'b0;
		slot = 3'h0;
		for (int i = 0; i < `IPB_NREG; i++)
		begin
			if (address == REG_OFS[i])
			begin
				hit = 1'b1;
				slot = i[2:0];
			end
		end
		is_stat = (address == `IPB_OFS_STAT);
	end

	always_comb
	begin
		stat = 16'h0000;
		stat[`IPB_STAT_REQ] = irq_q.req;
		stat[`IPB_STAT_LVL +: 3] = irq_q.level;
		stat[`IPB_STAT_SRC +: 4] = irq_q.source;
	end

	// Bus handshake: one wait cycle, then the access completes
	always_comb
	begin
		wait_d = !((read | write) & wait_q);
		rdata_d = rdata_q;
		if (read & wait_q)
		begin
			if (hit)
				rdata_d = {16'h0000, regs_q[slot]};
			else if (is_stat)
				rdata_d = {16'h0000, stat};
			else
				rdata_d = 32'h0000_0000;
		end
	end

	// Priority register writes, byte lanes 0 and 1 only
	always_comb
	begin
		regs_d = regs_q;
		merged = regs_q[slot];
		if (byteenable[0])
			merged[7:0] = writedata[7:0];
		if (byteenable[1])
			merged[15:8] = writedata[15:8];
		if (write & !wait_q & hit)
			regs_d[slot] = merged & REG_MASK[slot];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			regs_q <= REG_RST;
		end
		else
		begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			regs_q <= regs_d;
		end
	end

	// Per-source level extraction and gating
	generate
		for (genvar g = 0; g < `IPB_NSRC; g++)
		begin : g_src
			assign src_level[g] = regs_q[SRC_SLOT[g]][SRC_POS[g] +: 3];
			// A zero field leaves the source silent whatever its flag
			assign live_level[g] = (src_flag[g] & src_enable[g]) ? src_level[g] : 3'h0;
		end
	endgenerate

	// Highest level wins; on a tie the lower source index wins
	always_comb
	begin
		best_lvl = 3'h0;
		best_src = 4'h0;
		for (int i = 0; i < `IPB_NSRC; i++)
		begin
			if (live_level[i] > best_lvl)
			begin
				best_lvl = live_level[i];
				best_src = i[3:0];
			end
		end
		irq_d.level = best_lvl;
		irq_d.source = best_src;
		irq_d.req = (best_lvl != 3'h0) && ({1'b0, best_lvl} > cpu_level);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			irq_q <= '0;
		else
			irq_q <= irq_d;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	bus_wait_a: assert property ((read | write) & waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("access not answered after one wait cycle");

	reset_level_a: assert property ($rose(resetn) |-> src_level[0] == 3'h4 &&
		src_level[7] == 3'h4 && src_level[11] == 3'h4 && src_level[15] == 3'h4)
		else $error("source level not 4 after reset");

	read_zero_a: assert property (read & waitrequest & hit |=>
		readdata[31:16] == 16'h0000 && (readdata[15:0] & ~REG_MASK[$past(slot)]) == 16'h0000)
		else $error("unimplemented bits read nonzero");

	write_update_a: assert property (write & !waitrequest & hit & byteenable == 4'h3 |=>
		regs_q[$past(slot)] == ($past(writedata[15:0]) & REG_MASK[$past(slot)]))
		else $error("priority register did not take the write");

	field_map_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL4 &
		byteenable == 4'h3 & writedata[15:0] == 16'h1357 |=> src_level[3] == 3'h1 &&
		src_level[4] == 3'h3 && src_level[5] == 3'h5 && src_level[6] == 3'h7)
		else $error("control 4 fields misplaced");

	disabled_quiet_a: assert property (src_level[2] == 3'h0 |=>
		!(irq.req && irq.source == 4'h2))
		else $error("disabled source raised a request");

	above_core_a: assert property (irq.req |-> {1'b0, irq.level} > $past(cpu_level))
		else $error("request not above core level");

	level_linear_a: assert property (irq.req |->
		irq.level == $past(live_level[irq_d.source]))
		else $error("forwarded level differs from field");

	top_wins_a: assert property (live_level[9] == 3'h7 && cpu_level < 4'h7 |=>
		irq.req && irq.level == 3'h7)
		else $error("highest pending level not forwarded");

	// Field placement, checked on a write pattern with a distinct code per field
	ctrl3_map_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL3 &
		byteenable == 4'h3 & writedata[15:0] == 16'h1357 |=> src_level[0] == 3'h1 &&
		src_level[1] == 3'h5 && src_level[2] == 3'h7)
		else $error("control 3 fields misplaced");

	ctrl5_map_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL5 &
		byteenable == 4'h3 & writedata[15:0] == 16'h1357 |=> src_level[7] == 3'h7)
		else $error("control 5 field misplaced");

	ctrl7_map_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL7 &
		byteenable == 4'h3 & writedata[15:0] == 16'h1357 |=> src_level[8] == 3'h1 &&
		src_level[9] == 3'h3 && src_level[10] == 3'h5)
		else $error("control 7 fields misplaced");

	ctrl15_map_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL15 &
		byteenable == 4'h3 & writedata[15:0] == 16'h1357 |=> src_level[11] == 3'h3)
		else $error("control 15 field misplaced");

	ctrl16_map_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL16 &
		byteenable == 4'h3 & writedata[15:0] == 16'h1357 |=> src_level[12] == 3'h1 &&
		src_level[13] == 3'h3 && src_level[14] == 3'h5)
		else $error("control 16 fields misplaced");

	ctrl18_map_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL18 &
		byteenable == 4'h3 & writedata[15:0] == 16'h1357 |=> src_level[15] == 3'h7)
		else $error("control 18 field misplaced");

	// Unimplemented positions stay clear after an all-ones write
	ctrl3_unimp_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL3 &
		byteenable == 4'h3 & writedata[15:0] == 16'hffff |=> regs_q[0] == 16'h7077)
		else $error("control 3 kept an unimplemented bit");

	ctrl5_unimp_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL5 &
		byteenable == 4'h3 & writedata[15:0] == 16'hffff |=> regs_q[2] == 16'h0007)
		else $error("control 5 kept an unimplemented bit");

	ctrl7_unimp_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL7 &
		byteenable == 4'h3 & writedata[15:0] == 16'hffff |=> regs_q[3] == 16'h7770)
		else $error("control 7 kept an unimplemented bit");

	ctrl15_unimp_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL15 &
		byteenable == 4'h3 & writedata[15:0] == 16'hffff |=> regs_q[4] == 16'h0700)
		else $error("control 15 kept an unimplemented bit");

	ctrl16_unimp_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL16 &
		byteenable == 4'h3 & writedata[15:0] == 16'hffff |=> regs_q[5] == 16'h7770)
		else $error("control 16 kept an unimplemented bit");

	ctrl18_unimp_a: assert property (write & !waitrequest & address == `IPB_OFS_CTRL18 &
		byteenable == 4'h3 & writedata[15:0] == 16'hffff |=> regs_q[6] == 16'h0007)
		else $error("control 18 kept an unimplemented bit");

	lane_low_a: assert property (write & !waitrequest & hit & byteenable == 4'h1 |=>
		regs_q[$past(slot)][15:8] == $past(regs_q[slot][15:8]) &&
		regs_q[$past(slot)][7:0] == ($past(writedata[7:0]) & REG_MASK[$past(slot)][7:0]))
		else $error("low lane write wrong or touched the high byte");

	lane_high_a: assert property (write & !waitrequest & hit & byteenable == 4'h2 |=>
		regs_q[$past(slot)][7:0] == $past(regs_q[slot][7:0]) &&
		regs_q[$past(slot)][15:8] == ($past(writedata[15:8]) & REG_MASK[$past(slot)][15:8]))
		else $error("high lane write wrong or touched the low byte");

	stat_read_a: assert property (read & waitrequest & is_stat |=>
		readdata[31:16] == 16'h0000 && readdata[15] == $past(irq.req) &&
		readdata[14:11] == 4'h0 && readdata[10:8] == $past(irq.level) &&
		readdata[7:4] == 4'h0 && readdata[3:0] == $past(irq.source))
		else $error("status read differs from the forwarded request");

	idle_wait_a: assert property (!(read | write) |=> waitrequest)
		else $error("waitrequest low without an access");

	reset_out_a: assert property ($rose(resetn) |-> !irq.req && irq.level == 3'h0 &&
		waitrequest && readdata == 32'h0000_0000)
		else $error("outputs not at their reset values");

	zero_level_a: assert property (irq.level == 3'h0 |-> !irq.req && irq.source == 4'h0)
		else $error("request or source shown with no pending level");

	write_seen_c: cover property (write & !waitrequest & hit);
	stat_read_c: cover property (read & !waitrequest & is_stat);
	req_top_c: cover property (irq.req && irq.level == 3'h7);
	req_blocked_c: cover property (irq.level != 3'h0 && !irq.req);
	lane_write_c: cover property (write & !waitrequest & hit & byteenable != 4'h3);

endmodule : ipb_priority_bank

// ---- testbench/ipb_core_model.sv ----
// Core-side model that holds the current processor priority level
`timescale 1ns/100ps
module ipb_core_model
	import ipb_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Level requested by the bench
	input wire logic [3:0] level_set,
	// Bank side
	output logic [3:0] cpu_level
);
	logic [3:0] level_d;
	logic [3:0] level_q;
	always_comb
	begin
		level_d = level_set;
	end
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			level_q <= 4'h0;
		else
			level_q <= level_d;
	end
	assign cpu_level = level_q;
endmodule : ipb_core_model

// ---- testbench/tb_interrupt_priority_bank.sv ----
// Self-checking bench for the interrupt priority bank
`timescale 1ns/100ps
`include "ipb_consts.svh"
module tb_interrupt_priority_bank
	import ipb_pkg::*;
;
	logic sys_clk, resetn, read, write, waitrequest;
	logic [7:0] address;
	logic [31:0] writedata, readdata, rd;
	logic [15:0] src_flag, src_enable;
	logic [3:0] level_set, cpu_level, be;
	ipb_irq_t irq;
	int errors = 0;
	int compares = 0;
	logic [7:0] ofs [7] = '{`IPB_OFS_CTRL3, `IPB_OFS_CTRL4, `IPB_OFS_CTRL5, `IPB_OFS_CTRL7,
		`IPB_OFS_CTRL15, `IPB_OFS_CTRL16, `IPB_OFS_CTRL18};
	logic [15:0] msk [7] = '{`IPB_MASK_CTRL3, `IPB_MASK_CTRL4, `IPB_MASK_CTRL5,
		`IPB_MASK_CTRL7, `IPB_MASK_CTRL15, `IPB_MASK_CTRL16, `IPB_MASK_CTRL18};
	logic [15:0] rst [7] = '{`IPB_RST_CTRL3, `IPB_RST_CTRL4, `IPB_RST_CTRL5,
		`IPB_RST_CTRL7, `IPB_RST_CTRL15, `IPB_RST_CTRL16, `IPB_RST_CTRL18};

	ipb_priority_bank dut (.sys_clk(sys_clk), .resetn(resetn), .address(address),
		.read(read), .write(write), .byteenable(be), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .src_flag(src_flag),
		.src_enable(src_enable), .cpu_level(cpu_level), .irq(irq));
	ipb_core_model core (.sys_clk(sys_clk), .resetn(resetn), .level_set(level_set),
		.cpu_level(cpu_level));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic results();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One Avalon access; the request stands until waitrequest is sampled low
	task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] wd);
		@(posedge sys_clk);
		address <= a;
		write <= we;
		read <= !we;
		writedata <= {16'h0000, wd};
		do @(posedge sys_clk); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic settle();
		repeat (3) @(posedge sys_clk);
	endtask : settle

	task automatic t_reset();
		for (int k = 0; k < 7; k++)
		begin
			bus(1'b0, ofs[k], 16'h0000);
			chk(rd, {16'h0000, rst[k]});
		end
		chk({24'h000000, irq}, 32'h0);
	endtask : t_reset

	task automatic t_mask();
		for (int k = 0; k < 7; k++)
		begin
			bus(1'b1, ofs[k], 16'hffff);
			bus(1'b0, ofs[k], 16'h0000);
			chk(rd, {16'h0000, msk[k]});
			bus(1'b1, ofs[k], 16'h0000);
		end
		bus(1'b1, 8'h00, 16'hffff);
		bus(1'b0, 8'h00, 16'h0000);
		chk(rd, 32'h0);
		src_flag <= 16'hffff;
		src_enable <= 16'hffff;
		settle();
		chk({24'h000000, irq}, 32'h0);
	endtask : t_mask

	task automatic t_arb();
		bus(1'b1, `IPB_OFS_CTRL7, 16'h0700);
		bus(1'b1, `IPB_OFS_CTRL3, 16'h0001);
		settle();
		chk({24'h000000, irq}, 32'hf9);
		bus(1'b0, `IPB_OFS_STAT, 16'h0000);
		chk(rd, 32'h0000_8709);
		bus(1'b1, `IPB_OFS_STAT, 16'hffff);
		bus(1'b0, `IPB_OFS_STAT, 16'h0000);
		chk(rd, 32'h0000_8709);
		level_set <= 4'h6;
		settle();
		chk({24'h000000, irq}, 32'hf9);
		level_set <= 4'h7;
		settle();
		chk({24'h000000, irq}, 32'h79);
		bus(1'b0, `IPB_OFS_STAT, 16'h0000);
		chk(rd, 32'h0000_0709);
		level_set <= 4'h0;
		bus(1'b1, `IPB_OFS_CTRL7, 16'h0000);
		settle();
		chk({24'h000000, irq}, 32'h92);
		src_enable <= 16'h0000;
		settle();
		chk({24'h000000, irq}, 32'h0);
	endtask : t_arb

	// Distinct code per field, then one source at a time, a tie and both byte lanes
	task automatic t_map();
		logic [2:0] lvl [16] = '{3'h1, 3'h5, 3'h7, 3'h1, 3'h3, 3'h5, 3'h7, 3'h7, 3'h1, 3'h3,
			3'h5, 3'h3, 3'h1, 3'h3, 3'h5, 3'h7};
		for (int k = 0; k < 7; k++)
		begin
			bus(1'b1, ofs[k], 16'h1357);
			bus(1'b0, ofs[k], 16'h0000);
			chk(rd, {16'h0000, 16'h1357 & msk[k]});
		end
		for (int s = 0; s < 16; s++)
		begin
			src_flag <= 16'h0001 << s;
			src_enable <= 16'h0001 << s;
			settle();
			chk({29'h0, irq.level}, {29'h0, lvl[s]});
			chk({28'h0, irq.source}, {28'h0, s[3:0]});
			chk({31'h0, irq.req}, 32'h1);
		end
		src_flag <= 16'h00c4;
		src_enable <= 16'h00c4;
		settle();
		chk({24'h000000, irq}, 32'hf2);
		be <= 4'h1;
		bus(1'b1, `IPB_OFS_CTRL4, 16'hffff);
		bus(1'b0, `IPB_OFS_CTRL4, 16'h0000);
		chk(rd, 32'h0000_1377);
		be <= 4'h2;
		bus(1'b1, `IPB_OFS_CTRL4, 16'h0000);
		bus(1'b0, `IPB_OFS_CTRL4, 16'h0000);
		chk(rd, 32'h0000_0077);
		be <= 4'h3;
		src_flag <= 16'h0000;
		src_enable <= 16'h0000;
	endtask : t_map

	// Reset in mid-run brings every field back to level 4
	task automatic t_rerst();
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		chk({31'h0, waitrequest}, 32'h1);
		chk(readdata, 32'h0);
		t_reset();
	endtask : t_rerst

	initial
	begin
		resetn = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0;
		src_flag = 16'h0000;
		src_enable = 16'h0000;
		level_set = 4'h0;
		be = 4'h3;
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		t_reset();
		t_mask();
		t_arb();
		t_map();
		t_rerst();
		results();
	end

	initial
	begin
		#50000;
		errors++;
		results();
	end
endmodule : tb_interrupt_priority_bank
